/* verilog/pcd_core.sv */
// Clock divider sequencer: reference select, prescaler, divider, gating, power
`timescale 1ns/100ps
`include "pcd_regs.svh"
module pcd_core import pcd_pkg::*; #(
    parameter int SETTLE = `PCD_SETTLE_CYCLES,
    parameter int SYNC = `PCD_SYNC_STAGES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic int_ref_i,
    input wire logic ext_ref_i,
    input wire logic output_gate_i,
    input wire logic shared_control_i,
    input wire logic [`PCD_WORD_W-1:0] mode_prescale_word_i,
    input wire logic [`PCD_WORD_W-1:0] divider_word_i,
    output logic divided_clock_o,
    output logic divided_clock_oe_n_o,
    output logic reference_clock_o,
    output logic reference_clock_oe_n_o,
    output logic osc_enable_o
);
    // Inputs are sampled on clk_i; each reference is a level sampled as data.
    pcd_mode_t mode;
    pcd_pwr_t pwr;
    logic gate_s, ctl_s, ctl_low_s;
    logic int_q, ext_q;
    logic [1:0] pre_cnt;
    logic int_branch, int_branch_q;
    logic use_ext, want_ext;
    logic ref_ext_on, ref_int_on, ref_hold;
    logic ref_clk, ref_clk_q;
    logic [`PCD_WORD_W:0] div_cnt;
    logic div_out, div_out_q;
    logic gate_q;
    logic [2:0] extra;
    logic [8:0] settle_cnt;
    logic pd_req, div_max;
    logic [`PCD_WORD_W-1:0] divisor_field;
    logic ref_rise;

    function automatic logic [`PCD_WORD_W:0] ratio(input logic [`PCD_WORD_W-1:0] f);
        return {1'b0, f} + 10'h002;
    endfunction

    always_comb begin
        mode.ext_sel = mode_prescale_word_i[`PCD_MODE_EXT_SEL];
        mode.bypass_all = mode_prescale_word_i[`PCD_MODE_BYPASS_ALL];
        mode.pre_bypass = mode_prescale_word_i[`PCD_MODE_PRE_BYPASS];
        mode.pre_ratio = mode_prescale_word_i[`PCD_MODE_PRE_RATIO];
        mode.pin_func = mode_prescale_word_i[`PCD_MODE_PIN_FUNC];
        mode.ref_dis = mode_prescale_word_i[`PCD_MODE_REF_DIS];
    end

    // Both control pins are asynchronous to the references
    pcd_sync #(.STAGES(SYNC)) u_gate_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i(output_gate_i),
        .q_o(gate_s)
    );
    pcd_sync #(.STAGES(SYNC)) u_ctl_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i(!shared_control_i),
        .q_o(ctl_low_s)
    );

    assign ctl_s = !ctl_low_s; // Sync clears low, pin idles high: no false edge
    assign want_ext = mode.pin_func ? mode.ext_sel : !ctl_s;
    assign pd_req = mode.pin_func && !ctl_s;
    assign div_max = (pwr == PCD_SETTLE);
    assign ref_rise = ref_clk && !ref_clk_q;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            int_q <= 1'b0;
            ext_q <= 1'b0;
        end else begin
            int_q <= int_ref_i;
            ext_q <= ext_ref_i;
        end
    end

    // Prescaler counts rising oscillator edges
    always_ff @(posedge clk_i) begin
        if (!rstn_i || pwr == PCD_DOWN) begin
            pre_cnt <= 2'h0;
        end else if (int_ref_i && !int_q) begin
            pre_cnt <= pre_cnt + 2'h1;
        end
    end

    // Ratio bit used only when both bypasses are clear
    always_comb begin
        if (mode.bypass_all || (mode.pre_bypass && !div_max)) begin
            int_branch = int_q;
        end else if (mode.pre_ratio && !div_max) begin
            int_branch = pre_cnt[0];
        end else begin
            int_branch = pre_cnt[1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            int_branch_q <= 1'b0;
        end else begin
            int_branch_q <= int_branch;
        end
    end

    // Reference switch; the external side is level triggered
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            use_ext <= 1'b0;
            ref_hold <= 1'b0;
        end else if (want_ext && !use_ext) begin
            if (int_branch_q && !int_branch) begin
                ref_hold <= 1'b1;
            end else if (ref_hold && !ext_q) begin
                use_ext <= 1'b1;
                ref_hold <= 1'b0;
            end
        end else if (!want_ext && use_ext) begin
            if (!ext_q) begin
                ref_hold <= 1'b1;
            end
            if (ref_hold && int_branch_q && !int_branch) begin
                use_ext <= 1'b0;
                ref_hold <= 1'b0;
            end
        end else begin
            ref_hold <= 1'b0;
        end
    end

    assign ref_ext_on = use_ext && !(ref_hold && !want_ext);
    assign ref_int_on = !use_ext && !ref_hold;
    always_comb begin
        ref_clk = 1'b0;
        if (pwr != PCD_DOWN) begin
            if (ref_ext_on) begin
                ref_clk = ext_q;
            end else if (ref_int_on) begin
                ref_clk = int_branch;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ref_clk_q <= 1'b0;
        end else begin
            ref_clk_q <= ref_clk;
        end
    end

    // Divider: high for the first half of the count
    assign divisor_field = div_max ? `PCD_DIV_MAX : divider_word_i;
    always_ff @(posedge clk_i) begin
        if (!rstn_i || ((!gate_q || pwr != PCD_RUN) && !div_out_q)) begin
            div_cnt <= '0;
        end else if (ref_rise) begin
            div_cnt <= (div_cnt + 10'h001 >= ratio(divisor_field)) ? 10'h000
                : div_cnt + 10'h001;
        end
    end
    assign div_out = mode.bypass_all ? ref_clk
        : (div_cnt < (ratio(divisor_field) >> 1));

    // Gate sampled on rising edges of the selected reference only
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            gate_q <= 1'b0;
        end else if (ref_rise) begin
            gate_q <= gate_s && pwr == PCD_RUN;
        end
    end

    // Divide-by-one gets one trailing pulse after the sample
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            extra <= 3'h0;
        end else if (gate_q && ref_rise && !(gate_s && pwr == PCD_RUN)) begin
            extra <= mode.bypass_all ? 3'h1 : 3'h0;
        end else if (extra != 3'h0 && !ref_clk && ref_clk_q) begin
            extra <= extra - 3'h1;
        end
    end

    // Held low only once low, so no pulse is cut short
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            div_out_q <= 1'b0;
        end else if ((gate_q && pwr == PCD_RUN) || extra != 3'h0) begin
            div_out_q <= div_out;
        end else if (!div_out) begin
            div_out_q <= 1'b0;
        end
    end

    // Power sequencer
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pwr <= PCD_SETTLE;
            settle_cnt <= 9'h000;
        end else begin
            case (pwr)
                PCD_RUN: begin
                    if (pd_req) begin
                        pwr <= PCD_GATE_OFF;
                    end
                end
                PCD_GATE_OFF: begin
                    if (!div_out_q && !gate_q && extra == 3'h0) begin
                        pwr <= PCD_REF_OFF;
                    end
                end
                PCD_REF_OFF: begin
                    if (!ref_clk && !ref_clk_q) begin
                        pwr <= PCD_DOWN;
                    end
                end
                PCD_DOWN: begin
                    if (!pd_req) begin
                        pwr <= PCD_SETTLE;
                        settle_cnt <= 9'h000;
                    end
                end
                PCD_SETTLE: begin
                    if (ref_rise) begin
                        settle_cnt <= settle_cnt + 9'h001;
                    end
                    if (settle_cnt >= 9'(SETTLE)) begin
                        pwr <= PCD_RUN;
                    end
                end
                default: pwr <= PCD_SETTLE;
            endcase
        end
    end

    // Output pins; output enables are active low, osc_enable_o is active high
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            divided_clock_o <= 1'b0;
            divided_clock_oe_n_o <= 1'b1;
            reference_clock_o <= 1'b0;
            reference_clock_oe_n_o <= 1'b1;
            osc_enable_o <= 1'b1;
        end else begin
            divided_clock_o <= div_out_q;
            divided_clock_oe_n_o <= !(pwr == PCD_RUN || pwr == PCD_GATE_OFF);
            reference_clock_o <= ref_clk_q;
            reference_clock_oe_n_o <= mode.ref_dis
                || !(pwr == PCD_RUN || pwr == PCD_GATE_OFF || pwr == PCD_REF_OFF);
            osc_enable_o <= pwr != PCD_DOWN;
        end
    end

    property p_gate_off_low;
        @(posedge clk_i) disable iff (!rstn_i)
        (!gate_q && extra == 3'h0 && !div_out_q) |=> !div_out_q;
    endproperty
    a_gate_off_low: assert property (p_gate_off_low) else $error("output rose while gated");
    property p_pd_tristate;
        @(posedge clk_i) disable iff (!rstn_i)
        (pwr == PCD_DOWN) |=> divided_clock_oe_n_o && reference_clock_oe_n_o && !osc_enable_o;
    endproperty
    a_pd_tristate: assert property (p_pd_tristate) else $error("pins driven in power-down");
    property p_ref_dis;
        @(posedge clk_i) disable iff (!rstn_i)
        mode.ref_dis |=> reference_clock_oe_n_o;
    endproperty
    a_ref_dis: assert property (p_ref_dis) else $error("reference pin driven while disabled");
    property p_run_on_high;
        @(posedge clk_i) disable iff (!rstn_i)
        (pwr == PCD_RUN && !pd_req) |=> pwr == PCD_RUN;
    endproperty
    a_run_on_high: assert property (p_run_on_high) else $error("left run with pin high");
    property p_sel_func;
        @(posedge clk_i) disable iff (!rstn_i)
        mode.pin_func |-> want_ext == mode.ext_sel;
    endproperty
    a_sel_func: assert property (p_sel_func) else $error("select bit not honoured");
    property p_ext_low;
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(use_ext) |-> !$past(ext_q);
    endproperty
    a_ext_low: assert property (p_ext_low) else $error("switched while external high");
    property p_div_reset;
        @(posedge clk_i) disable iff (!rstn_i)
        (!gate_q && !div_out_q) |=> div_cnt == 10'h000;
    endproperty
    a_div_reset: assert property (p_div_reset) else $error("divider not reset while gated");
    property p_pd_order;
        @(posedge clk_i) disable iff (!rstn_i)
        (pwr == PCD_REF_OFF) |-> !divided_clock_o;
    endproperty
    a_pd_order: assert property (p_pd_order) else $error("output high at reference stop");
    sequence s_div_quieted;
        (pwr == PCD_GATE_OFF) ##1 (pwr == PCD_REF_OFF);
    endsequence
    property p_pd_steps;
        @(posedge clk_i) disable iff (!rstn_i)
        s_div_quieted |=> divided_clock_oe_n_o && osc_enable_o;
    endproperty
    a_pd_steps: assert property (p_pd_steps) else $error("pd steps out of order");
endmodule

/* inc/pcd_regs.svh */
// Register fields, reset values and timing counts of the clock divider
`ifndef PCD_REGS_SVH
`define PCD_REGS_SVH
`define PCD_WORD_W 9
`define PCD_MODE_EXT_SEL 0
`define PCD_MODE_BYPASS_ALL 1
`define PCD_MODE_PRE_BYPASS 2
`define PCD_MODE_PRE_RATIO 3
`define PCD_MODE_PIN_FUNC 4
`define PCD_MODE_REF_DIS 5
`define PCD_MODE_RESET 9'h034
`define PCD_DIV_RESET 9'h000
`define PCD_DIV_MAX 9'h1ff
`define PCD_SETTLE_CYCLES 256
`define PCD_SYNC_STAGES 2
`endif

/* inc/pcd_pkg.sv */
// Types shared by the clock divider sequencer
package pcd_pkg;
    typedef struct packed {
        logic ref_dis;
        logic pin_func;
        logic pre_ratio;
        logic pre_bypass;
        logic bypass_all;
        logic ext_sel;
    } pcd_mode_t;
    typedef enum logic [2:0] {
        PCD_RUN,
        PCD_GATE_OFF,
        PCD_REF_OFF,
        PCD_DOWN,
        PCD_SETTLE
    } pcd_pwr_t;
    typedef struct packed {
        logic pin;
        logic oe_n;
    } pcd_pin_t;
endpackage

/* verilog/pcd_sync.sv */
// Multi-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module pcd_sync #(
    parameter int STAGES = 2
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic d_i,
    output logic q_o
);
    logic [STAGES-1:0] chain;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            chain <= '0;
        end else begin
            chain <= {chain[STAGES-2:0], d_i};
        end
    end
    assign q_o = chain[STAGES-1];
endmodule

/* tb/pcd_board.sv */
// Board-side model: free-running references for the divider
`timescale 1ns/100ps
module pcd_board #(
    parameter int INT_HALF = 2,
    parameter int EXT_HALF = 3
) (
    input wire logic clk_i,
    output logic int_ref_o,
    output logic ext_ref_o
);
    int int_cnt = 0;
    int ext_cnt = 0;
    logic int_q = 1'b0;
    logic ext_q = 1'b0;
    assign int_ref_o = int_q;
    assign ext_ref_o = ext_q;
    // Slow enough for sampling as data at the core clock
    always @(posedge clk_i) begin
        int_cnt <= (int_cnt == INT_HALF - 1) ? 0 : int_cnt + 1;
        if (int_cnt == INT_HALF - 1) begin
            int_q <= ~int_q;
        end
    end
    // External reference keeps toggling, never parked high
    always @(posedge clk_i) begin
        ext_cnt <= (ext_cnt == EXT_HALF - 1) ? 0 : ext_cnt + 1;
        if (ext_cnt == EXT_HALF - 1) begin
            ext_q <= ~ext_q;
        end
    end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the clock divider sequencer
`timescale 1ns/100ps
`include "pcd_regs.svh"
module testbench;
    typedef struct packed {
        logic [15:0] dper;
        logic [15:0] rper;
        logic roe;
        logic doe;
        logic osc;
    } pcd_exp_t;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic output_gate_i = 1'b1;
    logic shared_control_i = 1'b1;
    logic [`PCD_WORD_W-1:0] mode_prescale_word_i = 9'h010;
    logic [`PCD_WORD_W-1:0] divider_word_i = 9'h000;
    logic int_ref, ext_ref, dclk, doe_n, rclk, roe_n, osc_en;
    int errors = 0;
    int n_checks = 0;
    pcd_exp_t exp_q[$];
    pcd_exp_t e;
    logic [15:0] dcnt = 16'h0;
    logic [15:0] rcnt = 16'h0;
    logic [15:0] rlast = 16'h0;
    logic [15:0] hold = 16'h0;
    logic [15:0] rises = 16'h0;
    logic dprev = 1'b0;
    logic rprev = 1'b0;
    logic seen = 1'b0;
    always #2.5 clk_i = ~clk_i;
    pcd_board u_pcd_board (.clk_i(clk_i), .int_ref_o(int_ref), .ext_ref_o(ext_ref));
    pcd_core #(.SETTLE(4)) u_pcd_core (.clk_i(clk_i), .rstn_i(rstn_i), .int_ref_i(int_ref),
        .ext_ref_i(ext_ref), .output_gate_i(output_gate_i), .shared_control_i(shared_control_i),
        .mode_prescale_word_i(mode_prescale_word_i), .divider_word_i(divider_word_i),
        .divided_clock_o(dclk), .divided_clock_oe_n_o(doe_n), .reference_clock_o(rclk),
        .reference_clock_oe_n_o(roe_n), .osc_enable_o(osc_en));
    task automatic check(input logic [15:0] got, input logic [15:0] want);
        n_checks++;
        if (got !== want) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, want);
        end
    endtask
    task automatic final_report();
        if (errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check_flags(input pcd_exp_t x);
        if (x.rper != 16'h0) check(rlast, x.rper);
        check({15'h0, roe_n}, {15'h0, x.roe});
        check({15'h0, doe_n}, {15'h0, x.doe});
        check({15'h0, osc_en}, {15'h0, x.osc});
    endtask
    // Watcher: period between rises, or a quiet window when dper is zero
    always @(posedge clk_i) begin
        dcnt = dcnt + 16'h1;
        rcnt = rcnt + 16'h1;
        if (rclk === 1'b1 && rprev === 1'b0) begin
            rlast = rcnt;
            rcnt = 16'h0;
        end
        if (exp_q.size() != 0 && exp_q[0].dper == 16'h0) begin
            hold = hold + 16'h1;
            if (dclk === 1'b1 && dprev === 1'b0) rises = rises + 16'h1;
            if (hold == 16'd64) begin
                e = exp_q.pop_front();
                check(rises, 16'h0);
                check_flags(e);
                hold = 16'h0;
                rises = 16'h0;
            end
        end else if (dclk === 1'b1 && dprev === 1'b0) begin
            if (seen && exp_q.size() != 0) begin
                e = exp_q.pop_front();
                check(dcnt, e.dper);
                check_flags(e);
                seen = 1'b0;
            end else begin
                seen = exp_q.size() != 0;
            end
            dcnt = 16'h0;
        end
        dprev = dclk;
        rprev = rclk;
    end
    task automatic wait_push(input int per, input int rper, input logic roe, input logic doe,
            input logic osc);
        repeat (300 + 2 * per) @(posedge clk_i);
        exp_q.push_back('{per[15:0], rper[15:0], roe, doe, osc});
        for (int k = 0; k < 3 * per + 300 && exp_q.size() != 0; k++) begin
            @(posedge clk_i);
        end
    endtask
    task automatic run_case(input logic [8:0] mode, input logic [8:0] n, input logic ctl);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        mode_prescale_word_i <= mode;
        divider_word_i <= n;
        shared_control_i <= ctl;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
    endtask
    task automatic drive(input logic gate, input logic ctl);
        @(posedge clk_i);
        output_gate_i <= gate;
        shared_control_i <= ctl;
    endtask
    // Mode words cover each prescale, bypass and selector setting
    logic [8:0] modes [9] = '{9'h010, 9'h018, 9'h01c, 9'h011, 9'h012, 9'h013, 9'h000, 9'h001,
        9'h030};
    int rps [9] = '{16, 8, 4, 6, 4, 6, 6, 16, 16};
    logic [8:0] ctls = 9'h1bf;
    initial begin
        logic [8:0] n;
        void'($urandom(2504));
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            n = (i == 2) ? 9'h1ff : ((i == 0) ? 9'h000 : 9'($urandom % 12));
            run_case(modes[i], n, ctls[i]);
            wait_push(modes[i][1] ? rps[i] : rps[i] * (n + 2), modes[i][5] ? 0 : rps[i],
                modes[i][5], 1'b0, 1'b1);
        end
        // Gate off and on, then power-down and wake
        run_case(9'h018, 9'h003, 1'b1);
        wait_push(40, 8, 1'b0, 1'b0, 1'b1);
        drive(1'b0, 1'b1);
        wait_push(0, 8, 1'b0, 1'b0, 1'b1);
        drive(1'b1, 1'b1);
        wait_push(40, 8, 1'b0, 1'b0, 1'b1);
        drive(1'b1, 1'b0);
        wait_push(0, 0, 1'b1, 1'b1, 1'b0);
        drive(1'b1, 1'b1);
        wait_push(40, 8, 1'b0, 1'b0, 1'b1);
        // Live reference switching both ways
        run_case(9'h000, 9'h002, 1'b1);
        wait_push(64, 16, 1'b0, 1'b0, 1'b1);
        drive(1'b1, 1'b0);
        wait_push(24, 6, 1'b0, 1'b0, 1'b1);
        drive(1'b1, 1'b1);
        wait_push(64, 16, 1'b0, 1'b0, 1'b1);
        final_report();
    end
    initial begin
        repeat (90000) @(posedge clk_i);
        errors++;
        final_report();
    end
endmodule
